//--- dv/cfg_decode_properties.sv
`timescale 1ns/1ps
module cfg_decode_checker (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        clk_en,
    // Raw flash words
    input wire logic [31:0] nv_word0,
    input wire logic [31:0] nv_word1,
    // Decoded settings
    input wire logic        programmer_access_block,
    input wire logic        boot_flash_write_block,
    input wire logic [16:0] program_flash_protect_limit,
    input wire logic [3:0]  emulator_channel_select,
    input wire logic        boundary_port_enable,
    input wire logic        debugger_enable,
    input wire logic        watchdog_run,
    input wire logic        watchdog_window_disable,
    input wire logic [4:0]  watchdog_postscale_select,
    input wire logic        clock_switch_enable,
    input wire logic        clock_monitor_enable
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic seen_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seen_q <= 1'b0;
        end else if (clk_en) begin
            seen_q <= 1'b1;
        end
    end

    // First enabled edge after reset takes the words
    sequence capture_s;
        clk_en && !seen_q;
    endsequence

    code_protect_a: assert property (
        capture_s |=> programmer_access_block == !$past(nv_word0[28]))
        else $error("code protect not taken from word 0");
    boot_protect_a: assert property (
        capture_s |=> boot_flash_write_block == !$past(nv_word0[24]))
        else $error("boot protect not taken from word 0");
    channel_pick_a: assert property (
        capture_s |=> emulator_channel_select == (4'b1000 >> $past(nv_word0[4:3])))
        else $error("emulator channel wrong");
    jtag_copy_a: assert property (
        capture_s |=> boundary_port_enable == $past(nv_word0[2]))
        else $error("boundary port enable not copied");
    debug_forced_a: assert property (
        programmer_access_block |-> !debugger_enable)
        else $error("debugger enabled under code protection");
    hard_watchdog_a: assert property (
        capture_s ##0 nv_word1[23] |=> watchdog_run [*4])
        else $error("hard enabled watchdog not running");
    window_mode_a: assert property (
        capture_s |=> watchdog_window_disable == $past(nv_word1[22]))
        else $error("window mode bit wrong");
    postscale_clamp_a: assert property (
        capture_s ##0 nv_word1[20:16] > 5'h14 |=> watchdog_postscale_select == 5'h14)
        else $error("postscale code not clamped");
    monitor_switch_a: assert property (
        clock_monitor_enable |-> clock_switch_enable)
        else $error("monitor on without switching");
    settings_hold_a: assert property (
        seen_q |=> $stable({programmer_access_block, boot_flash_write_block,
            program_flash_protect_limit, emulator_channel_select, debugger_enable,
            watchdog_window_disable, watchdog_postscale_select, clock_switch_enable}))
        else $error("settings changed after capture");
endmodule

//--- dv/cfg_programmer_model.sv
`timescale 1ns/1ps
module cfg_programmer_model (
    // Contents the bench asks for
    input  wire logic [31:0] want0,
    input  wire logic [31:0] want1,
    // Words as left in flash
    output logic      [31:0] nv_word0,
    output logic      [31:0] nv_word1
);
    logic [1:0] posc;

    always_comb begin
        // Reserved bits: top bit of word 0 low, all others high
        nv_word0 = (want0 & cfg_decode_pkg::word0_used) | 32'h6EFF_03E0;
        posc = want1[9:8];
        // Never leave the selected primary oscillator switched off
        if (want1[2:1] == 2'b01 && posc == 2'b11) begin
            posc = 2'b10;
        end
        nv_word1 = (want1 & cfg_decode_pkg::word1_used) | 32'hFC20_0CF8;
        nv_word1[9:8] = posc;
    end
endmodule

//--- dv/device_config_word_decoder_tb.sv
`timescale 1ns/1ps
module device_config_word_decoder_tb;
    localparam logic [5:0]  prot_t [4] = '{6'h3F, 6'h3E, 6'h1F, 6'h00};
    localparam logic [16:0] lim_t [4] = '{17'h0_0000, 17'h0_0400, 17'h0_8000, 17'h0_8000};
    localparam logic [4:0]  ps_t [4]  = '{5'h00, 5'h07, 5'h14, 5'h1F};
    localparam logic [4:0]  pse_t [4] = '{5'h00, 5'h07, 5'h14, 5'h14};
    localparam logic [2:0]  win_t [4] = '{3'h6, 3'h4, 3'h3, 3'h2};
    localparam logic [2:0]  fn_t [4]  = '{3'h2, 3'h3, 3'h5, 3'h7};
    logic        hclk = 1'b0, hresetn = 1'b0, clk_en = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b010;
    logic [11:0] haddr = 12'h000;
    logic [31:0] hwdata = 32'h0000_0000, want0 = 32'h0000_0000, want1 = 32'h0000_0000;
    logic [31:0] nv_word0, nv_word1, hrdata, rd;
    logic        hreadyout, hresp, programmer_access_block, boot_flash_write_block;
    logic        program_flash_protect_en, boundary_port_enable, debugger_enable;
    logic        watchdog_run, watchdog_window_disable, clock_switch_enable;
    logic        clock_monitor_enable;
    logic [16:0] program_flash_protect_limit;
    logic [3:0]  emulator_channel_select, primary_oscillator_mode;
    logic [2:0]  watchdog_window_size, oscillator_source_select;
    logic [4:0]  watchdog_postscale_select;
    logic [1:0]  peripheral_bus_divisor_default;
    int          err_count = 0, checked = 0, cycles = 0;

    always #5 hclk = ~hclk;

    cfg_programmer_model i_prog (.want0, .want1, .nv_word0, .nv_word1);
    device_config_word_decoder i_dut (.hclk, .hresetn, .clk_en, .nv_word0, .nv_word1, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .programmer_access_block, .boot_flash_write_block, .program_flash_protect_en,
        .program_flash_protect_limit, .emulator_channel_select, .boundary_port_enable,
        .debugger_enable, .watchdog_window_size, .watchdog_run, .watchdog_window_disable,
        .watchdog_postscale_select, .clock_switch_enable, .clock_monitor_enable,
        .peripheral_bus_divisor_default, .primary_oscillator_mode, .oscillator_source_select);

    task automatic summarize;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Extra idle edge at the end lets write effects land before checks
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rdv);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rdv = hrdata;
        @(posedge hclk);
    endtask

    task automatic run_cfg(input int i);
        logic [1:0]  c;
        logic [31:0] w0, w1;
        c = 2'(i);
        w0 = {3'h0, c[0], 3'h0, c[1], 8'h00, prot_t[i], 5'h00, c, c[0], c};
        w1 = {6'h00, c, c[1], c[0], 1'b0, ps_t[i], c, c, 2'b00, c, 5'h00, fn_t[i]};
        want0 <= w0;
        want1 <= w1;
        hresetn <= 1'b0;
        clk_en <= 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        // Capture must wait for the enable
        repeat (3) @(posedge hclk);
        clk_en <= 1'b1;
        repeat (2) @(posedge hclk);
        want0 <= ~w0;
        want1 <= ~w1;
        @(posedge hclk);
        check("prog_block", programmer_access_block, !c[0]);
        check("boot_block", boot_flash_write_block, !c[1]);
        check("prot_en", program_flash_protect_en, prot_t[i] != 6'h3F);
        check("prot_limit", program_flash_protect_limit, lim_t[i]);
        check("emu_chan", emulator_channel_select, 4'b1000 >> c);
        check("dbg_en", debugger_enable, c == 2'b01);
        check("win_size", watchdog_window_size, win_t[i]);
        check("win_dis", watchdog_window_disable, c[0]);
        check("postscale", watchdog_postscale_select, pse_t[i]);
        check("clk_sw", {clock_switch_enable, clock_monitor_enable},
              {!c[1], c == 2'b00});
        check("pb_div", peripheral_bus_divisor_default, c);
        check("posc", primary_oscillator_mode, 4'b0001 << c);
        check("osc_src", oscillator_source_select, fn_t[i]);
        bus(1'b1, 12'h000, 32'hFFFF_FFFF, rd);
        bus(1'b0, 12'h000, 32'h0000_0000, rd);
        check("word0", rd, (w0 & cfg_decode_pkg::word0_used)
              | (c[0] ? 32'h0000_0000 : 32'h0000_0003));
        check("bus_resp", {hreadyout, hresp}, 2'b10);
        bus(1'b0, 12'h004, 32'h0000_0000, rd);
        check("word1", rd, w1 & cfg_decode_pkg::word1_used);
        bus(1'b0, 12'h008, 32'h0000_0000, rd);
        check("ctl_jtag", rd[3], c[0]);
        bus(1'b1, 12'h008, {28'h000_0000, !c[0], 3'h0}, rd);
        check("bnd_en", boundary_port_enable, !c[0]);
        bus(1'b1, 12'h010, 32'h0000_0001, rd);
        check("wdt_on", watchdog_run, 1'b1);
        bus(1'b1, 12'h010, 32'h0000_0000, rd);
        check("wdt_hard", watchdog_run, c[1]);
        bus(1'b0, 12'h00C, 32'h0000_0000, rd);
        check("status", rd[19:0], {lim_t[i], !c[0], !c[1], c[1]});
        bus(1'b0, 12'h0FC, 32'h0000_0000, rd);
        check("unmapped", rd, 32'h0000_0000);
        $display("test %0d done", i);
    endtask

    always @(posedge hclk) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            summarize();
        end
    end

    initial begin
        for (int i = 0; i < 4; i++) begin
            run_cfg(i);
        end
        summarize();
    end
endmodule

bind device_config_word_decoder cfg_decode_checker i_chk (.hclk, .hresetn, .clk_en,
    .nv_word0, .nv_word1, .programmer_access_block, .boot_flash_write_block,
    .program_flash_protect_limit, .emulator_channel_select, .boundary_port_enable,
    .debugger_enable, .watchdog_run, .watchdog_window_disable, .watchdog_postscale_select,
    .clock_switch_enable, .clock_monitor_enable);

//--- rtl/cfg_decode_pkg.sv
// Notes on behaviour
// - Code protect low blocks programmer flash access
// - Boot write protect low blocks boot writes
// - Flash protect field sets limit in 0x400 steps
// - Channel field picks emulator pin pair
// - Boundary port enable copied to control register
// - Debugger field forced to 11 under protection
// - Window size field picks watchdog window percent
// - Hard enable keeps watchdog on always
// - Window disable bit selects non-window mode
// - Postscale code gives divide ratio power two
// - Postscale codes above 10100 act as 10100
// - Clock switch field enables switching and monitor
// - Bus divisor field gives 1,2,4,8 divide
// - Oscillator mode field picks oscillator kind
package cfg_decode_pkg;

    // Register byte offsets on the bus
    localparam logic [11:0] word0_off        = 12'h000;
    localparam logic [11:0] word1_off        = 12'h004;
    localparam logic [11:0] control_off      = 12'h008;
    localparam logic [11:0] decoded_off      = 12'h00C;
    localparam logic [11:0] watchdog_ctl_off = 12'h010;

    // Word 0 fields
    localparam int code_protect_bit = 28;
    localparam int boot_protect_bit = 24;
    localparam int flash_prot_hi    = 15;
    localparam int flash_prot_lo    = 10;
    localparam int ice_hi           = 4;
    localparam int ice_lo           = 3;
    localparam int jtag_bit         = 2;
    localparam int dbg_hi           = 1;
    localparam int dbg_lo           = 0;

    // Word 1 fields
    localparam int winsz_hi        = 25;
    localparam int winsz_lo        = 24;
    localparam int wdten_bit       = 23;
    localparam int win_disable_bit = 22;
    localparam int postscale_hi    = 20;
    localparam int postscale_lo    = 16;
    localparam int cksm_hi         = 15;
    localparam int cksm_lo         = 14;
    localparam int pbdiv_hi        = 13;
    localparam int pbdiv_lo        = 12;
    localparam int posc_hi         = 9;
    localparam int posc_lo         = 8;
    localparam int osc_src_hi      = 2;
    localparam int osc_src_lo      = 0;

    // Reserved bit masks: keep programmable bits only
    localparam logic [31:0] word0_used = 32'h1100_FC1F;
    localparam logic [31:0] word1_used = 32'h03DF_F307;

    // Values used when words are not yet sampled
    localparam logic [31:0] word0_rst  = 32'h0000_0000;
    localparam logic [31:0] word1_rst  = 32'h0000_0000;

    localparam logic [5:0]  flash_prot_off_code  = 6'h3F;
    localparam logic [5:0]  flash_prot_max_code  = 6'h1F;
    localparam logic [16:0] flash_prot_step      = 17'h0_0400;
    localparam logic [16:0] flash_prot_max_limit = 17'h0_8000;
    localparam logic [4:0]  postscale_max        = 5'h14;
    localparam logic [1:0]  dbg_forced           = 2'h3;

    // Window sizes in eighths of the period
    localparam logic [2:0]  win_25   = 3'h2;
    localparam logic [2:0]  win_37   = 3'h3;
    localparam logic [2:0]  win_50   = 3'h4;
    localparam logic [2:0]  win_75   = 3'h6;

    // Control register bit positions
    localparam int ctl_jtag_bit = 3;
    localparam int wctl_on_bit  = 0;

    typedef enum logic [2:0] {
        st_capture = 3'b001,
        st_hold    = 3'b010,
        st_unused  = 3'b100
    } load_state_e;

endpackage

//--- rtl/device_config_word_decoder.sv
// Local design decisions: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module device_config_word_decoder (
    // Clock, reset, enable
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clk_en,
    // Nonvolatile configuration words from flash
    input  wire logic [31:0] nv_word0,
    input  wire logic [31:0] nv_word1,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Flash and debug settings
    output logic             programmer_access_block,
    output logic             boot_flash_write_block,
    output logic             program_flash_protect_en,
    output logic      [16:0] program_flash_protect_limit,
    output logic      [3:0]  emulator_channel_select,
    output logic             boundary_port_enable,
    output logic             debugger_enable,
    // Watchdog settings
    output logic      [2:0]  watchdog_window_size,
    output logic             watchdog_run,
    output logic             watchdog_window_disable,
    output logic      [4:0]  watchdog_postscale_select,
    // Clock settings
    output logic             clock_switch_enable,
    output logic             clock_monitor_enable,
    output logic      [1:0]  peripheral_bus_divisor_default,
    output logic      [3:0]  primary_oscillator_mode,
    output logic      [2:0]  oscillator_source_select
);

    cfg_decode_pkg::load_state_e state_q;
    logic [31:0] word0_q;
    logic [31:0] word1_q;
    logic        jtag_ctl_q;
    logic        wdt_sw_on_q;
    logic        ph_valid_q;
    logic        ph_write_q;
    logic [11:0] ph_addr_q;
    logic [31:0] rd_d;
    logic [5:0]  prot_code;
    logic [5:0]  prot_steps;
    logic [4:0]  ps_code;
    logic        protect_on;
    logic        ph_take;

    // Capture once after reset; flash words stay stable meanwhile
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= cfg_decode_pkg::st_capture;
            word0_q <= cfg_decode_pkg::word0_rst;
            word1_q <= cfg_decode_pkg::word1_rst;
        end else if (clk_en) begin
            case (state_q)
                cfg_decode_pkg::st_capture: begin
                    word0_q <= nv_word0 & cfg_decode_pkg::word0_used;
                    word1_q <= nv_word1 & cfg_decode_pkg::word1_used;
                    state_q <= cfg_decode_pkg::st_hold;
                end
                cfg_decode_pkg::st_hold: begin
                    state_q <= cfg_decode_pkg::st_hold;
                end
                default: begin
                    state_q <= cfg_decode_pkg::st_capture;
                end
            endcase
        end
    end

    // Until capture, outputs show the all-zero word: fully protected
    assign protect_on = !word0_q[cfg_decode_pkg::code_protect_bit];
    assign programmer_access_block = protect_on;
    assign boot_flash_write_block  = !word0_q[cfg_decode_pkg::boot_protect_bit];

    assign prot_code  = word0_q[cfg_decode_pkg::flash_prot_hi:cfg_decode_pkg::flash_prot_lo];
    assign prot_steps = cfg_decode_pkg::flash_prot_off_code - prot_code;
    assign program_flash_protect_en =
        (prot_code != cfg_decode_pkg::flash_prot_off_code);
    always_comb begin
        if (prot_code <= cfg_decode_pkg::flash_prot_max_code) begin
            program_flash_protect_limit = cfg_decode_pkg::flash_prot_max_limit;
        end else begin
            program_flash_protect_limit =
                17'(prot_steps * cfg_decode_pkg::flash_prot_step);
        end
    end

    // One-hot pair select: bit 0 is pair 1
    always_comb begin
        case (word0_q[cfg_decode_pkg::ice_hi:cfg_decode_pkg::ice_lo])
            2'b11:   emulator_channel_select = 4'b0001;
            2'b10:   emulator_channel_select = 4'b0010;
            2'b01:   emulator_channel_select = 4'b0100;
            default: emulator_channel_select = 4'b1000;
        endcase
    end

    // Control copy of the port enable; software may clear it later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            jtag_ctl_q <= 1'b0;
        end else if (clk_en) begin
            if (state_q == cfg_decode_pkg::st_capture) begin
                jtag_ctl_q <= nv_word0[cfg_decode_pkg::jtag_bit];
            end else if (ph_valid_q && ph_write_q && ph_addr_q == cfg_decode_pkg::control_off) begin
                jtag_ctl_q <= hwdata[cfg_decode_pkg::ctl_jtag_bit];
            end
        end
    end
    assign boundary_port_enable = jtag_ctl_q;

    // Debugger field reads as forced value under protection
    logic [1:0] dbg_eff;
    assign dbg_eff = protect_on ? cfg_decode_pkg::dbg_forced
                           : word0_q[cfg_decode_pkg::dbg_hi:cfg_decode_pkg::dbg_lo];
    assign debugger_enable = !dbg_eff[1];

    always_comb begin
        case (word1_q[cfg_decode_pkg::winsz_hi:cfg_decode_pkg::winsz_lo])
            2'b11:   watchdog_window_size = cfg_decode_pkg::win_25;
            2'b10:   watchdog_window_size = cfg_decode_pkg::win_37;
            2'b01:   watchdog_window_size = cfg_decode_pkg::win_50;
            default: watchdog_window_size = cfg_decode_pkg::win_75;
        endcase
    end

    // Software watchdog switch; hard enable overrides it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdt_sw_on_q <= 1'b0;
        end else if (clk_en) begin
            if (ph_valid_q && ph_write_q && ph_addr_q == cfg_decode_pkg::watchdog_ctl_off) begin
                wdt_sw_on_q <= hwdata[cfg_decode_pkg::wctl_on_bit];
            end
        end
    end
    assign watchdog_run = word1_q[cfg_decode_pkg::wdten_bit] | wdt_sw_on_q;
    assign watchdog_window_disable = word1_q[cfg_decode_pkg::win_disable_bit];

    assign ps_code = word1_q[cfg_decode_pkg::postscale_hi:cfg_decode_pkg::postscale_lo];
    assign watchdog_postscale_select = (ps_code > cfg_decode_pkg::postscale_max)
                                     ? cfg_decode_pkg::postscale_max
                                     : ps_code;

    assign clock_switch_enable  = !word1_q[cfg_decode_pkg::cksm_hi];
    assign clock_monitor_enable = !word1_q[cfg_decode_pkg::cksm_hi]
                                & !word1_q[cfg_decode_pkg::cksm_lo];
    assign peripheral_bus_divisor_default =
        word1_q[cfg_decode_pkg::pbdiv_hi:cfg_decode_pkg::pbdiv_lo];

    // One-hot: bit0 external clock, bit1 standard, bit2 high-speed, bit3 off
    always_comb begin
        case (word1_q[cfg_decode_pkg::posc_hi:cfg_decode_pkg::posc_lo])
            2'b11:   primary_oscillator_mode = 4'b1000;
            2'b10:   primary_oscillator_mode = 4'b0100;
            2'b01:   primary_oscillator_mode = 4'b0010;
            default: primary_oscillator_mode = 4'b0001;
        endcase
    end
    assign oscillator_source_select =
        word1_q[cfg_decode_pkg::osc_src_hi:cfg_decode_pkg::osc_src_lo];

    // AHB-Lite slave, zero wait states
    assign ph_take   = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_valid_q <= 1'b0;
            ph_write_q <= 1'b0;
            ph_addr_q  <= 12'h000;
        end else if (clk_en) begin
            if (hready) begin
                ph_valid_q <= ph_take;
                ph_write_q <= hwrite;
                ph_addr_q  <= haddr;
            end
        end
    end

    // Read data registered at address phase so hrdata is a flop
    always_comb begin
        case (haddr)
            cfg_decode_pkg::word0_off: begin
                rd_d = {word0_q[31:2], dbg_eff};
            end
            cfg_decode_pkg::word1_off: begin
                rd_d = word1_q;
            end
            cfg_decode_pkg::control_off: begin
                rd_d = 32'h0000_0000;
                rd_d[cfg_decode_pkg::ctl_jtag_bit] = jtag_ctl_q;
            end
            cfg_decode_pkg::decoded_off: begin
                rd_d = {12'h000, program_flash_protect_limit, programmer_access_block,
                        boot_flash_write_block, watchdog_run};
            end
            cfg_decode_pkg::watchdog_ctl_off: begin
                rd_d = 32'h0000_0000;
                rd_d[cfg_decode_pkg::wctl_on_bit] = wdt_sw_on_q;
            end
            default: begin
                rd_d = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (clk_en) begin
            if (ph_take && !hwrite) begin
                hrdata <= rd_d;
            end
        end
    end

endmodule
